// >>> lps_regs.sv
// Light and proximity sensor command register file with two-wire slave
// Contract
// - An 8-bit command code selects one register word.
// - Code 0x00 low byte is ambient configuration, reset 0x01, ambient shut down.
// - Ambient bits 7:5 pick integration time 50 to 800 ms.
// - Ambient bits 3:2 pick persistence of 1, 2, 4 or 8 results.
// - Ambient bit 1 enables the ambient threshold interrupt.
// - Code 0x00 high byte holds sensitivity and broadband enable, reset 0x01.
// - Ambient high and low thresholds at 0x01 and 0x02, reset zero.
// - Code 0x03 low byte is proximity configuration, reset 0x01.
// - Code 0x03 high byte holds gain, resolution, trigger mode, reset zero.
// - Code 0x04 holds smart persistence, force mode and emitter current.
// - Code 0x05 holds the proximity cancellation level, reset zero.
// - Proximity low and high thresholds at 0x06 and 0x07, reset zero.
// - Code 0x0C reads the broadband result, zero after reset.
// - Code 0x0D high byte reads event flags, zero after reset.
// - Code 0x0E reads an identification word.
// - Word transfers only: low byte first, then high byte.
// - Reading the flag byte clears flags and releases the interrupt pin.
// - Ambient event only above the high or below the low threshold.
`timescale 1ns/10ps
`include "lps_cfg.svh"

module lps_regs #(
  parameter int unsigned MS_CYCLES = `LPS_MS_CYC,
  parameter logic [6:0]  DEV_ADDR  = `LPS_DEV_ADDR,
  parameter logic [7:0]  IDENT_LO  = `LPS_IDENT_LO,   // Arbitrary value
  parameter logic [7:0]  IDENT_HI  = `LPS_IDENT_HI    // Arbitrary value
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output wire logic             sda_o,
  output wire logic             sda_oe_o,
  output wire logic             int_o,
  output wire logic             int_oe_o,
  input  wire lps_pkg::lps_word_t amb_result_i,
  input  wire logic             amb_valid_i,
  input  wire lps_pkg::lps_word_t white_result_i,
  input  wire logic             white_valid_i,
  input  wire lps_pkg::lps_word_t prox_result_i,
  input  wire logic             prox_valid_i,
  input  wire logic             sun_flag_i,
  output wire lps_pkg::lps_word_t amb_cfg_o,
  output wire lps_pkg::lps_word_t prox_cfg_o,
  output wire lps_pkg::lps_word_t prox_cfg3_o,
  output wire lps_pkg::lps_word_t prox_cancel_o,
  output wire logic             amb_start_o
);
  import lps_pkg::*;

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  lps_state_s_t r;
  lps_state_s_t n;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  lps_word_t  rd_word;
  logic       flag_clr;
  logic       amb_out;
  logic       amb_on;
  logic [3:0] amb_need;
  logic       amb_fire;
  logic       prx_near;
  logic       prx_away;
  logic       prx_on;
  logic [2:0] prx_need;
  logic       prx_fire;
  logic [7:0] set_bits;
  logic [9:0] it_ms;

  // ----------------------------------------------------------------
  // Bus line events
  // ----------------------------------------------------------------
  assign scl_rise  = r.scl_s2 & ~r.scl_d;
  assign scl_fall  = ~r.scl_s2 & r.scl_d;
  assign start_det = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign stop_det  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    case (r.cmd)
      `LPS_CMD_AMB_CFG:  rd_word = r.amb_cfg;
      `LPS_CMD_AMB_HI:   rd_word = r.amb_hi;
      `LPS_CMD_AMB_LO:   rd_word = r.amb_lo;
      `LPS_CMD_PRX_CFG:  rd_word = r.prx_cfg;
      `LPS_CMD_PRX_CFG3: rd_word = r.prx_cfg3;
      `LPS_CMD_PRX_CANC: rd_word = r.prx_canc;
      `LPS_CMD_PRX_LO:   rd_word = r.prx_lo;
      `LPS_CMD_PRX_HI:   rd_word = r.prx_hi;
      `LPS_CMD_PRX_RES:  rd_word = r.prx_res;
      `LPS_CMD_AMB_RES:  rd_word = r.amb_res;
      `LPS_CMD_WHT_RES:  rd_word = r.wht_res;
      `LPS_CMD_FLAGS:    rd_word = {r.flags, 8'h00};
      `LPS_CMD_IDENT:    rd_word = {IDENT_HI, IDENT_LO};
      default:           rd_word = 16'h0000;
    endcase
  end

  // Flags cleared once the flag byte has gone out to the host
  assign flag_clr = (r.st == ST_RACK) && scl_fall && !start_det && !stop_det
                    && (r.phase == 2'd3) && (r.cmd == `LPS_CMD_FLAGS);

  // ----------------------------------------------------------------
  // Threshold monitors
  // ----------------------------------------------------------------
  assign amb_out  = (amb_result_i > r.amb_hi) || (amb_result_i < r.amb_lo);
  assign amb_on   = ~r.amb_cfg[`LPS_AMB_SD] & r.amb_cfg[`LPS_AMB_IRQ_EN];
  assign amb_need = 4'h1 << r.amb_cfg[`LPS_AMB_PERS_MSB:`LPS_AMB_PERS_LSB];
  assign amb_fire = amb_valid_i && amb_on && amb_out && (r.amb_pers + 4'h1 == amb_need);

  assign prx_near = (prox_result_i > r.prx_hi) & r.prx_cfg[`LPS_PRX_TRIG_LSB];
  assign prx_away = (prox_result_i < r.prx_lo) & r.prx_cfg[`LPS_PRX_TRIG_MSB];
  assign prx_on   = ~r.prx_cfg[`LPS_PRX_SD];
  assign prx_need = {1'b0, r.prx_cfg[`LPS_PRX_PERS_MSB:`LPS_PRX_PERS_LSB]} + 3'h1;
  assign prx_fire = prox_valid_i && prx_on && (prx_near || prx_away)
                    && (r.prx_pers + 3'h1 == prx_need);

  always_comb
  begin
    set_bits = 8'h00;
    set_bits[`LPS_FLG_AMB_HIGH] = amb_fire && (amb_result_i > r.amb_hi);
    set_bits[`LPS_FLG_AMB_LOW]  = amb_fire && (amb_result_i < r.amb_lo);
    set_bits[`LPS_FLG_PRX_NEAR] = prx_fire && prx_near;
    set_bits[`LPS_FLG_PRX_AWAY] = prx_fire && prx_away;
    set_bits[`LPS_FLG_SUN]      = sun_flag_i;
  end

  always_comb
  begin
    case (r.amb_cfg[`LPS_AMB_IT_MSB:`LPS_AMB_IT_LSB])
      3'h0:    it_ms = `LPS_IT0_MS;
      3'h1:    it_ms = `LPS_IT1_MS;
      3'h2:    it_ms = `LPS_IT2_MS;
      3'h3:    it_ms = `LPS_IT3_MS;
      default: it_ms = `LPS_IT4_MS;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n           = r;
    n.amb_start = 1'b0;
    n.scl_s1    = scl_i;
    n.scl_s2    = r.scl_s1;
    n.scl_d     = r.scl_s2;
    n.sda_s1    = sda_i;
    n.sda_s2    = r.sda_s1;
    n.sda_d     = r.sda_s2;

    // Start and stop win over any byte in progress
    if (stop_det)
    begin
      n.st      = ST_IDLE;
      n.sda_drv = 1'b0;
    end
    else if (start_det)
    begin
      n.st      = ST_RX;
      n.bitcnt  = 4'h0;
      n.phase   = 2'd0;
      n.sda_drv = 1'b0;
    end
    else
    begin
      case (r.st)
        ST_RX:
        begin
          if (scl_rise)
          begin
            n.shreg  = {r.shreg[6:0], r.sda_s2};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          else if (scl_fall && r.bitcnt == 4'h8)
          begin
            n.st      = ST_ACK;
            n.sda_drv = 1'b1;
            case (r.phase)
              2'd0:
              begin
                if (r.shreg[7:1] == DEV_ADDR)
                  n.rw = r.shreg[0];
                else
                begin
                  n.st      = ST_IDLE;
                  n.sda_drv = 1'b0;
                end
              end
              2'd1: n.cmd    = r.shreg;
              2'd2: n.lo_buf = r.shreg;
              default:
              begin
                // Whole word lands at once when the high byte arrives
                case (r.cmd)
                  `LPS_CMD_AMB_CFG:  n.amb_cfg  = {r.shreg, r.lo_buf};
                  `LPS_CMD_AMB_HI:   n.amb_hi   = {r.shreg, r.lo_buf};
                  `LPS_CMD_AMB_LO:   n.amb_lo   = {r.shreg, r.lo_buf};
                  `LPS_CMD_PRX_CFG:  n.prx_cfg  = {r.shreg, r.lo_buf};
                  `LPS_CMD_PRX_CFG3: n.prx_cfg3 = {r.shreg, r.lo_buf};
                  `LPS_CMD_PRX_CANC: n.prx_canc = {r.shreg, r.lo_buf};
                  `LPS_CMD_PRX_LO:   n.prx_lo   = {r.shreg, r.lo_buf};
                  `LPS_CMD_PRX_HI:   n.prx_hi   = {r.shreg, r.lo_buf};
                  default:           n.lo_buf   = r.lo_buf;
                endcase
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            n.sda_drv = 1'b0;
            n.bitcnt  = 4'h0;
            if (r.phase == 2'd0 && r.rw)
            begin
              // Snapshot both bytes so the pair is coherent
              n.shreg   = rd_word[7:0];
              n.lo_buf  = rd_word[15:8];
              n.sda_drv = ~rd_word[7];
              n.st      = ST_TX;
              n.phase   = 2'd2;
            end
            else if (r.phase == 2'd3)
              n.st = ST_IDLE;
            else
            begin
              n.phase = r.phase + 2'd1;
              n.st    = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
            n.bitcnt = r.bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (r.bitcnt == 4'h8)
            begin
              n.sda_drv = 1'b0;
              n.st      = ST_RACK;
            end
            else
            begin
              n.shreg   = {r.shreg[6:0], 1'b0};
              n.sda_drv = ~r.shreg[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            n.acked = ~r.sda_s2;
          else if (scl_fall)
          begin
            if (r.phase == 2'd2 && r.acked)
            begin
              n.shreg   = r.lo_buf;
              n.sda_drv = ~r.lo_buf[7];
              n.st      = ST_TX;
              n.bitcnt  = 4'h0;
              n.phase   = 2'd3;
            end
            else
              n.st = ST_IDLE;
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end

    // Results and persistence counters
    if (amb_valid_i)
    begin
      n.amb_res = amb_result_i;
      if (amb_on && amb_out && !amb_fire)
        n.amb_pers = r.amb_pers + 4'h1;
      else
        n.amb_pers = 4'h0;
    end
    if (white_valid_i)
      n.wht_res = white_result_i;
    if (prox_valid_i)
    begin
      n.prx_res = prox_result_i;
      if (prx_on && (prx_near || prx_away) && !prx_fire)
        n.prx_pers = r.prx_pers + 3'h1;
      else
        n.prx_pers = 3'h0;
    end

    // Set wins over the read clear
    n.flags = (flag_clr ? 8'h00 : r.flags) | set_bits;

    // Integration period timer, cleared to zero while the ambient channel is off
    if (r.amb_cfg[`LPS_AMB_SD])
    begin
      n.ms_div = 16'h0000;
      n.it_cnt = 10'h000;
    end
    else if (r.ms_div == MS_LAST)
    begin
      n.ms_div = 16'h0000;
      if (r.it_cnt >= it_ms - 10'h001)
      begin
        n.it_cnt    = 10'h000;
        n.amb_start = 1'b1;
      end
      else
        n.it_cnt = r.it_cnt + 10'h001;
    end
    else
      n.ms_div = r.ms_div + 16'h0001;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      r          <= '0;
      r.scl_s1   <= 1'b1;
      r.scl_s2   <= 1'b1;
      r.scl_d    <= 1'b1;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
      r.sda_d    <= 1'b1;
      r.st       <= ST_IDLE;
      r.amb_cfg  <= `LPS_RST_AMB_CFG;
      r.prx_cfg  <= `LPS_RST_PRX_CFG;
      r.prx_cfg3 <= `LPS_RST_ZERO;
    end
    else
      r <= n;
  end

  assign sda_o         = 1'b0;
  assign sda_oe_o      = r.sda_drv;
  assign int_o         = 1'b0;
  assign int_oe_o      = |r.flags;
  assign amb_cfg_o     = r.amb_cfg;
  assign prox_cfg_o    = r.prx_cfg;
  assign prox_cfg3_o   = r.prx_cfg3;
  assign prox_cancel_o = r.prx_canc;
  assign amb_start_o   = r.amb_start;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_RESET_CFG: assert property ($past(rst_i) |->
      r.amb_cfg == `LPS_RST_AMB_CFG && r.prx_cfg == `LPS_RST_PRX_CFG && r.flags == 8'h00)
    else $error("Configuration reset value wrong");
  AST_NO_START_OFF: assert property ($past(r.amb_cfg[0]) |-> !amb_start_o)
    else $error("Integration started while shut down");
  AST_START_WRAP: assert property (amb_start_o |-> r.it_cnt == 10'h000
      && r.ms_div == 16'h0000 && $past(r.it_cnt) >= $past(it_ms) - 10'h001)
    else $error("Integration period wrong");
  AST_PERS_BOUND: assert property (r.amb_pers < amb_need)
    else $error("Ambient persistence count overran");
  AST_IRQ_GATE: assert property ((amb_valid_i && !r.amb_cfg[1]) |=>
      (r.flags[5:4] & ~$past(r.flags[5:4])) == 2'b00)
    else $error("Ambient event while interrupt disabled");
  AST_WINDOW: assert property (amb_fire |-> amb_out ##1 (r.flags[5:4] != 2'b00))
    else $error("Ambient event without leaving window");
  AST_READ_CLEAR: assert property ((flag_clr && set_bits == 8'h00) |=>
      r.flags == 8'h00 && !int_oe_o)
    else $error("Flag read did not clear");
  AST_RO_HOLD: assert property (!$past(amb_valid_i) && !$past(prox_valid_i) |->
      $stable(r.amb_res) && $stable(r.prx_res))
    else $error("Result changed without new data");
  AST_ADDR_ACK: assert property ((r.st == ST_ACK && r.phase == 2'd0) |->
      sda_oe_o && $past(r.shreg[7:1]) == DEV_ADDR)
    else $error("Acknowledge without address match");

endmodule // lps_regs

// >>> lps_cfg.svh
// Constants of the light and proximity sensor register file
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define LPS_CLK_HZ       25000000
`define LPS_MS_PER_S     1000
`define LPS_MS_CYC       (`LPS_CLK_HZ / `LPS_MS_PER_S)
`define LPS_IT0_MS       10'd50
`define LPS_IT1_MS       10'd100
`define LPS_IT2_MS       10'd200
`define LPS_IT3_MS       10'd400
`define LPS_IT4_MS       10'd800

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define LPS_CMD_AMB_CFG  8'h00
`define LPS_CMD_AMB_HI   8'h01
`define LPS_CMD_AMB_LO   8'h02
`define LPS_CMD_PRX_CFG  8'h03
`define LPS_CMD_PRX_CFG3 8'h04
`define LPS_CMD_PRX_CANC 8'h05
`define LPS_CMD_PRX_LO   8'h06
`define LPS_CMD_PRX_HI   8'h07
`define LPS_CMD_PRX_RES  8'h08
`define LPS_CMD_TEST_09  8'h09
`define LPS_CMD_TEST_0A  8'h0a
`define LPS_CMD_AMB_RES  8'h0b
`define LPS_CMD_WHT_RES  8'h0c
`define LPS_CMD_FLAGS    8'h0d
`define LPS_CMD_IDENT    8'h0e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPS_RST_AMB_CFG  16'h0101
`define LPS_RST_PRX_CFG  16'h0001
`define LPS_RST_ZERO     16'h0000

// ----------------------------------------------------------------
// Field positions (within the 16-bit word; flag bits within the flag byte)
// ----------------------------------------------------------------
`define LPS_AMB_SD       0
`define LPS_AMB_IRQ_EN   1
`define LPS_AMB_PERS_LSB 2
`define LPS_AMB_PERS_MSB 3
`define LPS_AMB_IT_LSB   5
`define LPS_AMB_IT_MSB   7
`define LPS_PRX_SD       0
`define LPS_PRX_PERS_LSB 4
`define LPS_PRX_PERS_MSB 5
`define LPS_PRX_TRIG_LSB 8
`define LPS_PRX_TRIG_MSB 9
`define LPS_FLG_PRX_AWAY 0
`define LPS_FLG_PRX_NEAR 1
`define LPS_FLG_AMB_HIGH 4
`define LPS_FLG_AMB_LOW  5
`define LPS_FLG_SUN      6

// ----------------------------------------------------------------
// Bus address and identification (values arbitrary)
// ----------------------------------------------------------------
`define LPS_DEV_ADDR     7'h2a
`define LPS_IDENT_LO     8'ha5
`define LPS_IDENT_HI     8'h5a

`endif

// >>> lps_pkg.sv
// Types of the light and proximity sensor register file
package lps_pkg;

  typedef logic [15:0] lps_word_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } lps_state_t;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    lps_state_t st;
    logic [3:0] bitcnt;
    logic [1:0] phase;
    logic       rw;
    logic       acked;
    logic       sda_drv;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] lo_buf;
    lps_word_t  amb_cfg;
    lps_word_t  amb_hi;
    lps_word_t  amb_lo;
    lps_word_t  prx_cfg;
    lps_word_t  prx_cfg3;
    lps_word_t  prx_canc;
    lps_word_t  prx_lo;
    lps_word_t  prx_hi;
    lps_word_t  prx_res;
    lps_word_t  amb_res;
    lps_word_t  wht_res;
    logic [7:0] flags;
    logic [3:0] amb_pers;
    logic [2:0] prx_pers;
    logic [15:0] ms_div;
    logic [9:0] it_cnt;
    logic       amb_start;
  } lps_state_s_t;

endpackage

// >>> lps_host.sv
// Two-wire bus host model that reaches the sensor register file
`timescale 1ns/10ps

module lps_host #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int         HALF = 8
) (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ------------------------------------------------------------
  // Pin phases
  // ------------------------------------------------------------
  // Data only moves while the clock is low, so no false start or stop
  task automatic put(input logic s, input logic c);
    sda_o <= s;
    scl_o <= c;
    repeat (HALF) @(posedge mclk_i);
  endtask

  task automatic start();
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
    put(1'b0, 1'b1);
    put(1'b0, 1'b0);
  endtask

  task automatic stop();
    put(1'b0, 1'b0);
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
  endtask

  // Drive 1 to release; the pull-up then shows the device's bits
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic r);
    for (int i = 8; i >= 0; i--)
    begin
      put(i > 0 ? d[i - 1] : a, 1'b0);
      put(i > 0 ? d[i - 1] : a, 1'b1);
      if (i > 0)
        q[i - 1] = sda_i;
      else
        r = sda_i;
      put(i > 0 ? d[i - 1] : a, 1'b0);
    end
  endtask

  // ------------------------------------------------------------
  // Word transfers, low byte first
  // ------------------------------------------------------------
  task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                            input logic [15:0] w, output logic ok);
    logic [7:0] q;
    logic [3:0] n;
    start();
    byte_io({a, 1'b0}, 1'b1, q, n[0]);
    byte_io(c, 1'b1, q, n[1]);
    byte_io(w[7:0], 1'b1, q, n[2]);
    byte_io(w[15:8], 1'b1, q, n[3]);
    stop();
    ok = (n === 4'h0);
  endtask

  task automatic read_word(input logic [7:0] c, output logic [15:0] w, output logic ok);
    logic [7:0] q;
    logic [3:0] n;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, q, n[0]);
    byte_io(c, 1'b1, q, n[1]);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, q, n[2]);
    byte_io(8'hff, 1'b0, w[7:0], n[3]);
    byte_io(8'hff, 1'b1, w[15:8], n[3]);
    stop();
    ok = (n[2:0] === 3'h0);
  endtask
endmodule // lps_host

// >>> lps_regs_tb.sv
// Self-checking bench for the sensor register file
`timescale 1ns/10ps
`include "lps_cfg.svh"

module lps_regs_tb;
  import lps_pkg::*;
  localparam int unsigned MSC = 4;
  logic      mclk_i = 1'b0;
  logic      rst_i  = 1'b1;
  logic      scl, hsda, sda_oe, sda_do, int_do, int_oe, amb_st, sda_w, int_n;
  logic      amb_v = 1'b0, wht_v = 1'b0, prx_v = 1'b0, sun = 1'b0;
  lps_word_t res = '0, amb_cfg, prx_cfg, prx_cfg3, prx_canc, v;
  lps_word_t exp_w [8];
  lps_word_t lfsr = 16'h1bec;  // Seed 7148
  int        n_fail = 0;
  int        check_count = 0;
  int        n;
  logic      ok;

  assign sda_w = hsda & (sda_oe ? sda_do : 1'b1);  // Pull-up: either side may pull low
  assign int_n = int_oe ? int_do : 1'b1;  // Pull-up on the interrupt pin

  lps_regs #(.MS_CYCLES(MSC)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_do), .sda_oe_o(sda_oe), .int_o(int_do), .int_oe_o(int_oe),
    .amb_result_i(res), .amb_valid_i(amb_v), .white_result_i(res), .white_valid_i(wht_v),
    .prox_result_i(res), .prox_valid_i(prx_v), .sun_flag_i(sun), .amb_cfg_o(amb_cfg),
    .prox_cfg_o(prx_cfg), .prox_cfg3_o(prx_cfg3), .prox_cancel_o(prx_canc),
    .amb_start_o(amb_st));

  // Short bus phases keep the run well inside its cycle budget
  lps_host #(.ADDR(`LPS_DEV_ADDR), .HALF(4)) host (.mclk_i(mclk_i), .sda_i(sda_w),
    .scl_o(scl), .sda_o(hsda));

  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic lps_word_t rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic lps_word_t rst_val(input int c);
    case (c)
      0:       return `LPS_RST_AMB_CFG;
      3:       return `LPS_RST_PRX_CFG;
      14:      return {`LPS_IDENT_HI, `LPS_IDENT_LO};
      default: return `LPS_RST_ZERO;
    endcase
  endfunction

  function automatic int it_ms(input int t);
    return (t < 4) ? (50 << t) : 800;
  endfunction

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input lps_word_t seen, input lps_word_t exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input lps_word_t w);
    logic a;
    host.write_word(`LPS_DEV_ADDR, c, w, a);
    check({15'h0, a}, 16'h1);
  endtask

  task automatic rd(input logic [7:0] c, input lps_word_t e);
    lps_word_t w;
    logic      a;
    host.read_word(c, w, a);
    check({15'h0, a}, 16'h1);
    check(w, e);
  endtask

  // One sensing pulse: kind 0 ambient, 1 broadband, 2 proximity, 3 sunlight
  task automatic sense(input int k, input lps_word_t x);
    @(posedge mclk_i);
    res <= x;
    {amb_v, wht_v, prx_v, sun} <= 4'b1000 >> k;
    @(posedge mclk_i);
    {amb_v, wht_v, prx_v, sun} <= 4'h0;
    repeat (3) @(posedge mclk_i);
  endtask

  // Sampled on the falling edge, clear of the output's own update
  task automatic wait_start(output int cnt);
    cnt = 0;
    do
    begin
      @(negedge mclk_i);
      cnt++;
      if (cnt > 4000)
      begin
        n_fail++;
        report_and_stop();
      end
    end while (amb_st !== 1'b1);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check(amb_cfg, 16'h0101);
    check(prx_cfg, 16'h0001);
    check(prx_cfg3, 16'h0000);
    // Flag word 0x0d is never written: its low byte is for test only
    for (int c = 0; c < 16; c++)
    begin
      rd(c[7:0], rst_val(c));
      if (c inside {8, 11, 12, 14, 15})
      begin
        wr(c[7:0], rnd());
        rd(c[7:0], rst_val(c));
      end
    end
    $display("test reset values done");
    for (int r = 0; r < 3; r++)
      for (int c = 0; c < 8; c++)
      begin
        exp_w[c] = rnd();
        wr(c[7:0], exp_w[c]);
      end
    for (int c = 0; c < 8; c++)
      rd(c[7:0], exp_w[c]);
    check(amb_cfg, exp_w[0]);
    check(prx_cfg, exp_w[3]);
    check(prx_cfg3, exp_w[4]);
    check(prx_canc, exp_w[5]);
    host.write_word(`LPS_DEV_ADDR ^ 7'h01, 8'h05, ~exp_w[5], ok);
    check({15'h0, ok}, 16'h0);
    rd(8'h05, exp_w[5]);
    $display("test read write done");
    wr(8'h00, 16'h0101);
    wr(8'h03, 16'h0001);
    for (int k = 0; k < 3; k++)
    begin
      v = rnd();
      sense(k, v);
      rd(k == 0 ? 8'h0b : (k == 1 ? 8'h0c : 8'h08), v);
    end
    $display("test results done");
    wr(8'h01, 16'h1000);
    wr(8'h02, 16'h0100);
    wr(8'h00, 16'h0102);
    sense(0, 16'h1000);
    sense(0, 16'h0100);
    check({15'h0, int_oe}, 16'h0);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h00, {8'h01, 4'h0, p[1:0], 2'b10});
      sense(0, 16'h0800);
      for (int i = 1; i < (1 << p); i++)
        sense(0, 16'h1001);
      check({15'h0, int_oe}, 16'h0);
      sense(0, 16'h1001);
      check({15'h0, int_oe}, 16'h1);
      check({15'h0, int_n}, 16'h0);
      rd(8'h0d, 16'h1000);
      check({15'h0, int_oe}, 16'h0);
      check({15'h0, int_n}, 16'h1);
    end
    wr(8'h00, 16'h0102);
    sense(0, 16'h00ff);
    rd(8'h0d, 16'h2000);
    wr(8'h00, 16'h0100);
    sense(0, 16'h2000);
    check({15'h0, int_oe}, 16'h0);
    wr(8'h07, 16'h0300);
    wr(8'h03, 16'h0100);
    sense(2, 16'h0400);
    check({15'h0, int_oe}, 16'h1);
    check({15'h0, int_n}, 16'h0);
    rd(8'h0d, 16'h0200);
    rd(8'h08, 16'h0400);
    sense(3, 16'h0000);
    rd(8'h0d, 16'h4000);
    // Away trigger only, two results in a row needed
    wr(8'h06, 16'h0200);
    wr(8'h03, 16'h0210);
    sense(2, 16'h0100);
    check({15'h0, int_oe}, 16'h0);
    sense(2, 16'h0100);
    rd(8'h0d, 16'h0100);
    $display("test interrupts done");
    for (int t = 0; t < 8; t++)
    begin
      wr(8'h00, {8'h01, t[2:0], 5'h00});
      wait_start(n);
      wait_start(n);
      check(n[15:0], lps_word_t'(it_ms(t) * MSC));
    end
    $display("test integration time done");
    report_and_stop();
  end
endmodule // lps_regs_tb
